// [hdl/taisp_pkg.sv]
// Constants, types and register map for the touch converter bus host.
// Assumes a 100 MHz system clock and an open-drain two-wire bus.
package taisp_pkg;

  // System clock and the three bus clock ceilings.
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int SCL_STD_HZ = 100_000;
  localparam int SCL_FAST_HZ = 400_000;
  localparam int SCL_HS_HZ = 3_400_000;

  // Quarter bus period in clock cycles, rounded up so no rate is exceeded.
  localparam int QTR_STD = (SYS_CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
  localparam int QTR_FAST =
    (SYS_CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
  localparam int QTR_HS = (SYS_CLK_HZ + 4 * SCL_HS_HZ - 1) / (4 * SCL_HS_HZ);

  // Width of the tick divider count.
  localparam int DIV_W = 16;

  // Software register map, byte addresses.
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;

  // Configuration field positions.
  localparam int CFG_SEL_LSB = 0;
  localparam int CFG_SPD_LSB = 2;
  localparam int CFG_AUTO8 = 4;
  // Command register: bit above the command byte asks for a write only.
  localparam int CMD_WONLY = 8;
  // Status field positions.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_NACK = 2;
  localparam int ST_IDLE = 3;

  // Speed codes.
  localparam logic [1:0] SPD_STD = 2'h0;
  localparam logic [1:0] SPD_FAST = 2'h1;

  // Fixed upper part of the device address and direction values.
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h12;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;

  // Command byte layout: channel code on top, mode bit next to last.
  localparam int CMD_MODE_BIT = 1;
  localparam logic [2:0] CHAN_PRESSURE_TOP = 3'h7;

  // Bit counter values within a byte.
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Phases of one bus bit, a quarter period each.
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  typedef enum logic [2:0] {
    TAISP_IDLE, TAISP_WAIT_BUS, TAISP_START, TAISP_BIT, TAISP_RESTART,
    TAISP_STOP
  } taisp_state_e;

  typedef enum logic [1:0] {
    TAISP_ADDR_W, TAISP_CMD_BYTE, TAISP_ADDR_R, TAISP_READ
  } taisp_step_e;

endpackage

// [hdl/taisp_tick_div.sv]
// Quarter-period tick divider for the bus host.
// Assumes one system clock; the load value is at least one.
`timescale 1ns/1ps
module taisp_tick_div
  import taisp_pkg::*;
#(
  parameter int W = taisp_pkg::DIV_W
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic [W-1:0] load,
  output logic tick
);
  import taisp_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } taisp_div_s;

  taisp_div_s div_r;
  taisp_div_s div_nxt;

  // Count down while enabled and pulse once per reload.
  always_comb
  begin
    div_nxt = div_r;
    div_nxt.tick = 1'b0;
    if (!en)
    begin
      div_nxt.cnt = load;
    end
    else if (div_r.cnt <= W'(1))
    begin
      div_nxt.cnt = load;
      div_nxt.tick = 1'b1;
    end
    else
    begin
      div_nxt.cnt = div_r.cnt - W'(1);
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
    end
  end

  assign tick = div_r.tick;

endmodule // taisp_tick_div

// [hdl/taisp_line_sync.sv]
// Two-flop synchroniser with a stability filter for one bus line.
// Assumes the line idles high, as an open-drain bus does.
`timescale 1ns/1ps
module taisp_line_sync
#(
  parameter int FILT = 3
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic [FILT-1:0] hist;
    logic level;
  } taisp_sync_s;

  taisp_sync_s sy_r;
  taisp_sync_s sy_nxt;

  // The filtered level follows only after FILT equal samples, so short
  // glitches never reach the host state machine.
  always_comb
  begin
    sy_nxt = sy_r;
    sy_nxt.s1 = pin;
    sy_nxt.s2 = sy_r.s1;
    sy_nxt.hist = {sy_r.hist[FILT-2:0], sy_r.s2};
    if (&sy_r.hist)
    begin
      sy_nxt.level = 1'b1;
    end
    else if (~|sy_r.hist)
    begin
      sy_nxt.level = 1'b0;
    end
  end

  // State register; everything resets to the idle-high level.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sy_r <= '1;
    end
    else
    begin
      sy_r <= sy_nxt;
    end
  end

  assign level = sy_r.level;

endmodule // taisp_line_sync

// [hdl/taisp_host.sv]
// Bus host that commands the touch converter over the two-wire bus.
// Assumes open-drain pins resolved outside; software uses a plain port.
//
// Overview of operation
// [RULE1] Code 0000 selects single diode temperature reading.
// [RULE2] Code 0100 selects ratio diode temperature reading.
// [RULE3] Device biases diode only while acquiring.
// [RULE4] Device divides battery input by four.
// [RULE5] Device powers battery divider only while sampling.
// [RULE6] Host uses 8-bit mode for pressure.
// [RULE7] Host makes all clocks, starts and stops.
// [RULE8] Host starts only on an idle bus.
// [RULE9] Data changes only while clock low.
// [RULE10] Start is data falling while clock high.
// [RULE11] Stop is data rising while clock high.
// [RULE12] Eight bits then a ninth acknowledge clock.
// [RULE13] Host alone sets byte count per transfer.
// [RULE14] Works at standard, fast and high speed.
// [RULE15] Acknowledger holds data low through clock high.
// [RULE16] Host ends read with no acknowledge.
// [RULE17] Device acknowledges address and each written byte.
// [RULE18] Host acknowledges all read bytes but last.
// [RULE19] Transfer ends by stop or repeated start.
// [RULE20] Direction bit selects device receive or transmit.
// [RULE21] Device shifts read data on host clock.
// [RULE22] Address is fixed code, select pins, direction.
// [RULE23] Command: channel, power bits, mode, spare bit.
// [RULE24] Device refuses extra command bytes in transfer.
// [RULE25] Device filters and synchronises bus inputs.
`timescale 1ns/1ps
module taisp_host
  import taisp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  import taisp_pkg::*;

  typedef struct packed {
    taisp_state_e st;
    taisp_step_e step;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rdcnt;
    logic ack_n;
    logic [7:0] cmd;
    logic wonly;
    logic [1:0] dev_sel;
    logic [1:0] speed;
    logic auto8;
    logic busy;
    logic done;
    logic nack;
    logic [15:0] result;
    logic [31:0] rdata;
    logic scl_oe_n;
    logic sda_oe_n;
  } taisp_host_s;

  taisp_host_s h_r;
  taisp_host_s h_nxt;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic [DIV_W-1:0] qtr;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Address byte from the fixed code, select pins and direction.
  function automatic logic [7:0] addr_byte(input logic [1:0] sel,
                                           input logic dir);
    addr_byte = {DEV_ADDR_FIXED, sel, dir}; // [RULE22] [RULE20]
  endfunction

  // Quarter period for the chosen bus speed.
  function automatic logic [DIV_W-1:0] qtr_count(input logic [1:0] spd);
    if (spd == SPD_STD)
    begin
      qtr_count = DIV_W'(QTR_STD);
    end
    else if (spd == SPD_FAST)
    begin
      qtr_count = DIV_W'(QTR_FAST);
    end
    else
    begin
      qtr_count = DIV_W'(QTR_HS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs and bit timing.

  // Both lines pass two flops and a glitch filter before use.
  taisp_line_sync u_scl_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin(scl_i),
    .level(scl_s)
  ); // [RULE25]

  taisp_line_sync u_sda_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin(sda_i),
    .level(sda_s)
  ); // [RULE25]

  assign qtr = qtr_count(h_r.speed); // [RULE14]

  // Quarter-period ticks run only while a transfer is under way.
  taisp_tick_div u_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .en(h_r.st != TAISP_IDLE),
    .load(qtr),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register port and transfer sequencer.

  // Software access first, then the bus engine, so that a flag set by
  // the engine wins over a clear in the same cycle.
  always_comb
  begin
    h_nxt = h_r;
    h_nxt.rdata = 32'h0;
    if (rd)
    begin
      unique case (addr)
        REG_CFG: h_nxt.rdata = 32'({h_r.auto8, h_r.speed, h_r.dev_sel});
        REG_CMD: h_nxt.rdata = 32'({h_r.wonly, h_r.cmd});
        REG_STATUS: h_nxt.rdata = 32'({scl_s & sda_s, h_r.nack, h_r.done,
                                       h_r.busy});
        REG_RESULT: h_nxt.rdata = 32'(h_r.result);
        default: h_nxt.rdata = 32'h0;
      endcase
    end
    if (wr && addr == REG_CFG && !h_r.busy)
    begin
      h_nxt.dev_sel = wdata[CFG_SEL_LSB +: 2];
      h_nxt.speed = wdata[CFG_SPD_LSB +: 2];
      h_nxt.auto8 = wdata[CFG_AUTO8];
    end
    if (wr && addr == REG_STATUS)
    begin
      if (wdata[ST_DONE])
      begin
        h_nxt.done = 1'b0;
      end
      if (wdata[ST_NACK])
      begin
        h_nxt.nack = 1'b0;
      end
    end
    unique case (h_r.st)
      TAISP_IDLE:
      begin
        // A command write starts a transfer; ignored while busy.
        if (wr && addr == REG_CMD)
        begin
          h_nxt.cmd = wdata[7:0]; // [RULE23]
          // Pressure channels are forced to the coarse mode on request.
          if (h_r.auto8 && wdata[7:5] == CHAN_PRESSURE_TOP)
          begin
            h_nxt.cmd[CMD_MODE_BIT] = 1'b1; // [RULE6]
          end
          h_nxt.wonly = wdata[CMD_WONLY];
          h_nxt.busy = 1'b1;
          h_nxt.nack = 1'b0;
          h_nxt.done = 1'b0;
          h_nxt.step = TAISP_ADDR_W;
          h_nxt.st = TAISP_WAIT_BUS;
        end
      end
      TAISP_WAIT_BUS:
      begin
        // Start only when both lines are seen high.
        if (tick && scl_s && sda_s)
        begin
          h_nxt.sda_oe_n = 1'b0; // [RULE8] [RULE10] [RULE7]
          h_nxt.st = TAISP_START;
        end
      end
      TAISP_START:
      begin
        if (tick)
        begin
          h_nxt.scl_oe_n = 1'b0;
          h_nxt.sh = addr_byte(h_r.dev_sel, DIR_WRITE);
          h_nxt.bitn = 4'h0;
          h_nxt.ph = PH_SET;
          h_nxt.st = TAISP_BIT;
        end
      end
      TAISP_BIT:
      begin
        if (tick)
        begin
          unique case (h_r.ph)
            PH_SET:
            begin
              // Data moves only in the clock-low quarter.
              if (h_r.step != TAISP_READ)
              begin
                h_nxt.sda_oe_n = (h_r.bitn == ACK_SLOT) ? 1'b1 : h_r.sh[7];
              end
              else if (h_r.bitn != ACK_SLOT)
              begin
                h_nxt.sda_oe_n = 1'b1; // [RULE21]
              end
              else
              begin
                // Acknowledge all but the last byte, release on the last.
                h_nxt.sda_oe_n = (h_r.rdcnt == h_r.cmd[CMD_MODE_BIT])
                                 ? 1'b0 : 1'b1; // [RULE18] [RULE16] [RULE15]
              end
              h_nxt.ph = PH_RISE; // [RULE9]
            end
            PH_RISE:
            begin
              h_nxt.scl_oe_n = 1'b1; // [RULE7]
              h_nxt.ph = PH_SAMPLE;
            end
            PH_SAMPLE:
            begin
              // Wait here while the clock line is held low by anyone.
              if (scl_s)
              begin
                if (h_r.bitn == ACK_SLOT)
                begin
                  h_nxt.ack_n = sda_s; // [RULE12]
                end
                else if (h_r.step == TAISP_READ)
                begin
                  h_nxt.sh = {h_r.sh[6:0], sda_s}; // [RULE21]
                end
                h_nxt.ph = PH_FALL;
              end
            end
            PH_FALL:
            begin
              h_nxt.scl_oe_n = 1'b0;
              h_nxt.ph = PH_SET;
              h_nxt.bitn = h_r.bitn + 4'h1;
              if (h_r.bitn == ACK_SLOT)
              begin
                h_nxt.bitn = 4'h0;
                unique case (h_r.step)
                  TAISP_ADDR_W:
                  begin
                    h_nxt.sh = h_r.cmd;
                    h_nxt.step = TAISP_CMD_BYTE;
                    if (h_r.ack_n)
                    begin
                      h_nxt.nack = 1'b1; // [RULE17]
                      h_nxt.st = TAISP_STOP;
                    end
                  end
                  TAISP_CMD_BYTE:
                  begin
                    // One command byte per write, then stop or restart.
                    if (h_r.ack_n)
                    begin
                      h_nxt.nack = 1'b1; // [RULE17]
                      h_nxt.st = TAISP_STOP;
                    end
                    else if (h_r.wonly)
                    begin
                      h_nxt.st = TAISP_STOP; // [RULE24] [RULE19]
                    end
                    else
                    begin
                      h_nxt.st = TAISP_RESTART; // [RULE24] [RULE19]
                    end
                  end
                  TAISP_ADDR_R:
                  begin
                    h_nxt.step = TAISP_READ;
                    h_nxt.rdcnt = 1'b0;
                    if (h_r.ack_n)
                    begin
                      h_nxt.nack = 1'b1;
                      h_nxt.st = TAISP_STOP;
                    end
                  end
                  TAISP_READ:
                  begin
                    // Two bytes in fine mode, one in coarse mode.
                    if (h_r.rdcnt)
                    begin
                      h_nxt.result[7:0] = h_r.sh;
                    end
                    else
                    begin
                      h_nxt.result = {h_r.sh, 8'h0};
                    end
                    if (h_r.rdcnt == !h_r.cmd[CMD_MODE_BIT])
                    begin
                      h_nxt.st = TAISP_STOP; // [RULE13]
                    end
                    h_nxt.rdcnt = 1'b1;
                  end
                endcase
              end
              else
              begin
                // Transmit shift register moves on after each data bit.
                if (h_r.step != TAISP_READ)
                begin
                  h_nxt.sh = {h_r.sh[6:0], 1'b0};
                end
              end
            end
          endcase
        end
      end
      TAISP_RESTART:
      begin
        if (tick)
        begin
          unique case (h_r.ph)
            PH_SET: h_nxt.sda_oe_n = 1'b1;
            PH_RISE: h_nxt.scl_oe_n = 1'b1;
            PH_SAMPLE: h_nxt.sda_oe_n = scl_s ? 1'b0 : 1'b1; // [RULE19]
            PH_FALL:
            begin
              h_nxt.scl_oe_n = 1'b0;
              h_nxt.sh = addr_byte(h_r.dev_sel, DIR_READ);
              h_nxt.step = TAISP_ADDR_R;
              h_nxt.st = TAISP_BIT;
            end
          endcase
          if (h_r.ph != PH_SAMPLE || scl_s)
          begin
            h_nxt.ph = h_r.ph + 2'h1;
          end
        end
      end
      TAISP_STOP:
      begin
        if (tick)
        begin
          unique case (h_r.ph)
            PH_SET: h_nxt.sda_oe_n = 1'b0;
            PH_RISE: h_nxt.scl_oe_n = 1'b1;
            PH_SAMPLE: h_nxt.sda_oe_n = scl_s ? 1'b1 : 1'b0; // [RULE11]
            PH_FALL:
            begin
              h_nxt.busy = 1'b0;
              h_nxt.done = 1'b1;
              h_nxt.st = TAISP_IDLE;
            end
          endcase
          if (h_r.ph != PH_SAMPLE || scl_s)
          begin
            h_nxt.ph = h_r.ph + 2'h1;
          end
        end
      end
    endcase
  end

  // State register; the bus lines start released.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      h_r <= '0;
      h_r.scl_oe_n <= 1'b1;
      h_r.sda_oe_n <= 1'b1;
    end
    else
    begin
      h_r <= h_nxt;
    end
  end

  // Open-drain pins only ever pull low.
  assign scl_o = h_r.busy & 1'b0;
  assign sda_o = h_r.busy & 1'b0;
  assign scl_oe_n = h_r.scl_oe_n;
  assign sda_oe_n = h_r.sda_oe_n;
  assign rdata = h_r.rdata;

endmodule // taisp_host

// [tb/taisp_host_asserts.sv]
// Concurrent checks on the bus host's ports, bound into every instance.
// Assumes the two-wire lines are resolved outside with pull-ups.
`timescale 1ns/1ps
module taisp_host_asserts
  import taisp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // The clock line is only ever pulled low, never driven high.
  a_scl_open_drain: assert property (scl_o == 1'b0)
    else $error("clock line driven high");
  // The data line is only ever pulled low, never driven high.
  a_sda_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  // A start is only begun while both wires were seen high.
  a_start_idle: assert property ($fell(sda_oe_n) && scl_oe_n |->
    $past(sda_i) && $past(scl_i)) else $error("start on a busy bus");
  // After a start the data line stays low until the clock falls.
  a_start_hold: assert property ($fell(sda_oe_n) && scl_oe_n |->
    !sda_oe_n throughout (##[1:1000] $fell(scl_oe_n)))
    else $error("start condition broken");
  // A stop leaves both lines released for a while.
  a_stop_hold: assert property ($rose(sda_oe_n) && scl_oe_n |=>
    (sda_oe_n && scl_oe_n) [*8]) else $error("stop not held");
  // Clock low phase is at least one quarter of the fastest rate.
  a_scl_low_span: assert property ($fell(scl_oe_n) |->
    !scl_oe_n [*8]) else $error("clock low phase too short");
  // Clock high phase is at least one quarter of the fastest rate.
  a_scl_high_span: assert property ($rose(scl_oe_n) |->
    scl_oe_n [*8]) else $error("clock high phase too short");
  // Read data is zero outside the cycle after a read.
  a_rdata_quiet: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside its cycle");
  // An unmapped address reads as zero.
  a_unmapped_zero: assert property (rd && addr == 8'h10 |=>
    rdata == 32'h0) else $error("unmapped address not zero");
endmodule // taisp_host_asserts

////////////////////////////////////////////////////////////////////////////
bind taisp_host taisp_host_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n(sda_oe_n));

// [tb/taisp_dev_model.sv]
// Behavioural model of the touch converter's two-wire slave port.
// Assumes pull-up resolved wires; the model never touches the clock line.
`timescale 1ns/1ps
module taisp_dev_model
#(
  parameter logic [1:0] SEL = 2'h2
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic [15:0] word,
  output logic sda_oe_n,
  output logic [7:0] cmd_seen,
  output logic [1:0] mack
);
  logic [1:0] st = 2'h0;
  logic [3:0] bitn = 4'h0;
  logic [7:0] sh = 8'h0;
  logic [15:0] tx = 16'hffff;
  logic ack = 1'b0;
  logic got = 1'b0;
  initial sda_oe_n = 1'b1;
  initial cmd_seen = 8'h0;
  initial mack = 2'h0;

  // A falling data line with the clock high opens a new transfer.
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      st = 2'h1;
      bitn = 4'hf;
      got = 1'b0;
      mack = 2'h0;
    end
  // A rising data line with the clock high ends it.
  always @(posedge sda)
    if (scl === 1'b1)
      st = 2'h0;
  // Bits are taken MSB first while the clock is high.
  always @(posedge scl)
    if (st != 2'h0)
    begin
      if (bitn < 4'h8)
        sh = {sh[6:0], sda};
      else if (st == 2'h3)
      begin
        mack = {mack[0], sda};
        if (sda)
          st = 2'h0;
      end
    end
  // The data line changes only while the clock is low.
  always @(negedge scl)
  begin
    sda_oe_n = 1'b1;
    if (st != 2'h0 && bitn == 4'h7 && st != 2'h3)
    begin
      ack = (st == 2'h1) ? (sh[7:1] == {5'h12, SEL}) : !got;
      if (st == 2'h2 && !got)
        cmd_seen = sh;
      got = got | (st == 2'h2);
      sda_oe_n = !ack;
    end
    if (st == 2'h1 && bitn == 4'h8)
    begin
      st = !ack ? 2'h0 : (sh[0] ? 2'h3 : 2'h2);
      tx = word;
    end
    bitn = (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
    if (st == 2'h3 && bitn < 4'h8)
    begin
      sda_oe_n = tx[15];
      tx = {tx[14:0], 1'b1};
    end
  end
endmodule // taisp_dev_model

// [tb/test_taisp_host.sv]
// Self-checking bench for the bus host with a slave model on the wires.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module test_taisp_host;
  import taisp_pkg::*;
  localparam logic [1:0] DEV_SEL = 2'h2;
  logic ref_clk, nrst, wr, rd;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic scl_i, scl_o, scl_oe_n, sda_i, sda_o, sda_oe_n, dev_oe_n;
  logic [15:0] word;
  logic [7:0] dev_cmd;
  logic [1:0] mack;
  logic [31:0] st;
  logic [3:0] codes [6] = '{4'h0, 4'h4, 4'h1, 4'h5, 4'he, 4'hf};
  int n_checks, bad_count;

  // Pull-up wires: low when any party pulls.
  assign scl_i = scl_oe_n ? 1'b1 : scl_o;
  assign sda_i = (sda_oe_n ? 1'b1 : sda_o) & dev_oe_n;

  taisp_host DUT (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n));
  taisp_dev_model #(.SEL(DEV_SEL)) u_dev (.scl(scl_i), .sda(sda_i),
    .word(word), .sda_oe_n(dev_oe_n), .cmd_seen(dev_cmd), .mack(mack));

  // Clock of 10 ns period.
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////
  // Compares and counts.
  task automatic check(input logic [31:0] seen, exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // One register write, one cycle long.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // One register read; data are taken in the following cycle.
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Pressure channels may have 8-bit mode forced.
  function automatic logic [7:0] exp_cmd(input logic [7:0] c, input logic a8);
    exp_cmd = c;
    if (a8 && c[7:5] == CHAN_PRESSURE_TOP)
      exp_cmd[CMD_MODE_BIT] = 1'b1;
  endfunction
  // Result word: two bytes, or one byte on top in 8-bit mode.
  function automatic logic [31:0] exp_res(input logic [15:0] w, input logic m);
    exp_res = m ? {16'h0, w[15:8], 8'h0} : {16'h0, w};
  endfunction
  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One full command transfer with its status and data checks.
  task automatic xfer(input logic [1:0] sel, spd, input logic a8,
    input logic [7:0] cmd, input logic wo, poke);
    logic [31:0] s;
    logic [7:0] ec;
    logic nk;
    int n;
    ec = exp_cmd(cmd, a8);
    nk = (sel != DEV_SEL);
    word = 16'($urandom);
    wr_reg(REG_CFG, {27'h0, a8, spd, sel});
    wr_reg(REG_CMD, {23'h0, wo, cmd});
    if (poke)
      wr_reg(REG_CMD, {23'h0, wo, ~cmd});
    n = 0;
    s = 32'h1;
    while (s[ST_BUSY] !== 1'b0 && n < 30000)
    begin
      rd_reg(REG_STATUS, s);
      n++;
    end
    check(s, {28'h0, 1'b1, nk, 2'b10}, "status after transfer");
    rd_reg(REG_CMD, s);
    check(s, {23'h0, wo, ec}, "command readback");
    rd_reg(REG_CFG, s);
    check(s, {27'h0, a8, spd, sel}, "config readback");
    if (!nk)
      check({24'h0, dev_cmd}, {24'h0, ec}, "command at device");
    if (!nk && !wo)
    begin
      rd_reg(REG_RESULT, s);
      check(s, exp_res(word, ec[CMD_MODE_BIT]), "result");
      check({30'h0, mack}, 32'h1, "host ack pattern");
    end
    wr_reg(REG_STATUS, 32'h6);
    rd_reg(REG_STATUS, s);
    check(s, 32'h8, "flags cleared");
    $display("test done: sel %0d speed %0d cmd %h", sel, spd, cmd);
  endtask

  // Watchdog against a hang.
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  // Main sequence.
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    word = 16'h0;
    n_checks = 0;
    bad_count = 0;
    void'($urandom(32'h70c23fd9));
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    wr_reg(8'h10, 32'hffffffff);
    rd_reg(8'h10, st);
    check(st, 32'h0, "unmapped read");
    xfer(DEV_SEL, SPD_STD, 1'b0, {4'h1, 4'($urandom)}, 1'b1, 1'b0);
    xfer(DEV_SEL, SPD_FAST, 1'b0, 8'h00, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++)
      xfer((i == 3) ? ~DEV_SEL : DEV_SEL, 2'h2 + 2'(i & 1), 1'(i >> 2),
        {codes[i % 6], 4'($urandom)}, 1'b0, 1'b0);
    results();
  end
endmodule // test_taisp_host
